/* cpt_pkg.sv */
// Constants, register map and helper functions of the cascadable period timers.
package cpt_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int N_CH = 3;
	// Channel numbers: standalone, lower paired, upper paired.
	localparam int CH_S = 0;
	localparam int CH_L = 1;
	localparam int CH_U = 2;
	// Each channel owns three words: control, count, period.
	localparam int A_STRIDE = 3;
	localparam int A_CON_OFS = 0;
	localparam int A_CNT_OFS = 1;
	localparam int A_PER_OFS = 2;
	localparam logic [ADDR_W-1:0] A_FLAG = 4'h9;
	// Control bit positions.
	localparam int B_RUN = 15;
	localparam int B_IDLE = 13;
	localparam int B_GATE = 6;
	localparam int B_PS_HI = 5;
	localparam int B_PS_LO = 4;
	localparam int B_CASC = 3;
	localparam int B_SYNC = 2;
	localparam int B_CSRC = 1;
	// Implemented control bits of each channel.
	localparam logic [DATA_W-1:0] MASK_S = 16'hA076;
	localparam logic [DATA_W-1:0] MASK_L = 16'hA07A;
	localparam logic [DATA_W-1:0] MASK_U = 16'hA072;
	// Reset values.
	localparam logic [DATA_W-1:0] CON_RST = 16'h0000;
	localparam logic [DATA_W-1:0] CNT_RST = 16'h0000;
	localparam logic [DATA_W-1:0] PER_RST = 16'hFFFF;
	// Last prescaler count for each ratio.
	localparam logic [7:0] PS_L1 = 8'h00;
	localparam logic [7:0] PS_L8 = 8'h07;
	localparam logic [7:0] PS_L64 = 8'h3F;
	localparam logic [7:0] PS_L256 = 8'hFF;

	// Word address of one register of one channel.
	function automatic logic [ADDR_W-1:0] addr_of(input int c, input int k);
		addr_of = ADDR_W'(c * A_STRIDE + k);
	endfunction : addr_of

	// Terminal prescaler count for a prescale_select code.
	function automatic logic [7:0] psc_last(input logic [1:0] s);
		case (s)
			2'b00: psc_last = PS_L1;
			2'b01: psc_last = PS_L8;
			2'b10: psc_last = PS_L64;
			default: psc_last = PS_L256;
		endcase
	endfunction : psc_last

	// Writable bits of a channel's control register.
	function automatic logic [DATA_W-1:0] con_mask(input int c);
		con_mask = (c == CH_S) ? MASK_S : ((c == CH_L) ? MASK_L : MASK_U);
	endfunction : con_mask
endpackage : cpt_pkg

/* cpt_timers.sv */
// Standalone timer and cascadable timer pair with register port.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module cpt_timers
	import cpt_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_SRST,
	input wire logic [ADDR_W-1:0] I_ADDR,
	input wire logic [DATA_W-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [DATA_W-1:0] O_RDATA,
	input wire logic I_IDLE,
	input wire logic I_S_ECLK,
	input wire logic I_L_ECLK,
	input wire logic I_U_ECLK,
	output logic O_S_IRQ,
	output logic O_L_IRQ,
	output logic O_U_IRQ,
	output logic O_CONV_TRIG
);
	logic [DATA_W-1:0] con_q [N_CH];
	logic [DATA_W-1:0] con_d [N_CH];
	logic [DATA_W-1:0] cnt_q [N_CH];
	logic [DATA_W-1:0] cnt_d [N_CH];
	logic [DATA_W-1:0] per_q [N_CH];
	logic [DATA_W-1:0] per_d [N_CH];
	logic [7:0] psc_q [N_CH];
	logic [7:0] psc_d [N_CH];
	logic [DATA_W-1:0] econ [N_CH];
	logic [N_CH-1:0] flg_q;
	logic [N_CH-1:0] flg_d;
	logic [N_CH-1:0] s1_q;
	logic [N_CH-1:0] s2_q;
	logic [N_CH-1:0] s3_q;
	logic [N_CH-1:0] ext;
	logic [N_CH-1:0] gmode;
	logic [N_CH-1:0] run;
	logic [N_CH-1:0] in_tick;
	logic [N_CH-1:0] tick;
	logic [N_CH-1:0] match;
	logic [N_CH-1:0] gfall;
	logic [N_CH-1:0] set_flg;
	logic [N_CH-1:0] wr_con;
	logic [N_CH-1:0] wr_cnt;
	logic [N_CH-1:0] wr_per;
	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] rdata_q;
	logic conv_q;
	logic conv_d;

	// Cascade mode and the combined 32-bit views of count and period.
	wire casc = con_q[CH_L][B_CASC];
	wire [31:0] cnt32 = {cnt_q[CH_U], cnt_q[CH_L]};
	wire [31:0] per32 = {per_q[CH_U], per_q[CH_L]};
	wire m32 = (cnt32 == per32);
	wire [31:0] cnt32_inc = cnt32 + 32'h0000_0001;
	wire wr_flag = I_WR && (I_ADDR == A_FLAG);

	// Pin levels seen by each channel; cascaded, the upper channel uses the lower pin.
	wire [N_CH-1:0] p_lvl = {casc ? s2_q[CH_L] : s2_q[CH_U], s2_q[CH_L], s2_q[CH_S]};
	wire [N_CH-1:0] p_old = {casc ? s3_q[CH_L] : s3_q[CH_U], s3_q[CH_L], s3_q[CH_S]};
	wire [N_CH-1:0] p_rise = p_lvl & ~p_old;
	wire [N_CH-1:0] p_fall = ~p_lvl & p_old;

	// Three-flop sampling of the external clock and gate pins; only the second
	// and third flops feed logic, so the first may go metastable safely.
	always_ff @(posedge I_CORE_CLK)
	begin
		if (I_SRST)
		begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			s3_q <= 3'h0;
		end
		else
		begin
			s1_q <= {I_U_ECLK, I_L_ECLK, I_S_ECLK};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Per-channel control decode, clock selection, gating and prescaler tick.
	always_comb
	begin
		for (int c = 0; c < N_CH; c++)
		begin
			// Cascaded, the upper channel takes every setting from the lower one.
			econ[c] = (c == CH_U && casc) ? con_q[CH_L] : con_q[c];
			ext[c] = econ[c][B_CSRC];
			gmode[c] = econ[c][B_GATE] && !ext[c];
			run[c] = econ[c][B_RUN] && !(I_IDLE && econ[c][B_IDLE]);
			// Internal clock is one tick per core cycle; gated, only while the gate is high.
			in_tick[c] = ext[c] ? p_rise[c] : (gmode[c] ? p_lvl[c] : 1'b1);
			tick[c] = run[c] && in_tick[c] &&
				(psc_q[c] == psc_last(econ[c][B_PS_HI:B_PS_LO]));
			match[c] = (cnt_q[c] == per_q[c]);
			gfall[c] = run[c] && gmode[c] && p_fall[c];
			wr_con[c] = I_WR && (I_ADDR == addr_of(c, A_CON_OFS));
			wr_cnt[c] = I_WR && (I_ADDR == addr_of(c, A_CNT_OFS));
			wr_per[c] = I_WR && (I_ADDR == addr_of(c, A_PER_OFS));
		end
	end

	// Flag sources: cascaded events go to the upper flag only.
	always_comb
	begin
		set_flg[CH_S] = (tick[CH_S] && match[CH_S]) || gfall[CH_S];
		set_flg[CH_L] = !casc && ((tick[CH_L] && match[CH_L]) || gfall[CH_L]);
		if (casc)
		begin
			set_flg[CH_U] = (tick[CH_L] && m32) || gfall[CH_L];
		end
		else
		begin
			set_flg[CH_U] = (tick[CH_U] && match[CH_U]) || gfall[CH_U];
		end
		conv_d = casc ? (tick[CH_L] && m32) : (tick[CH_U] && match[CH_U]);
	end

	// Next count and prescaler values; a software write to a count wins over counting.
	always_comb
	begin
		for (int c = 0; c < N_CH; c++)
		begin
			cnt_d[c] = cnt_q[c];
			if (tick[c])
			begin
				cnt_d[c] = match[c] ? CNT_RST : cnt_q[c] + 16'h0001;
			end
			// A control write while running restarts the prescale sequence.
			if (!run[c] || (wr_con[c] && con_q[c][B_RUN]))
			begin
				psc_d[c] = 8'h00;
			end
			else if (in_tick[c])
			begin
				psc_d[c] = tick[c] ? 8'h00 : psc_q[c] + 8'h01;
			end
			else
			begin
				psc_d[c] = psc_q[c];
			end
		end
		if (casc)
		begin
			// One 32-bit counter on the lower channel's tick; the upper prescaler idles.
			psc_d[CH_U] = 8'h00;
			if (tick[CH_L])
			begin
				{cnt_d[CH_U], cnt_d[CH_L]} = m32 ? {CNT_RST, CNT_RST} : cnt32_inc;
			end
			else
			begin
				{cnt_d[CH_U], cnt_d[CH_L]} = cnt32;
			end
		end
		for (int c = 0; c < N_CH; c++)
		begin
			if (wr_cnt[c])
			begin
				cnt_d[c] = I_WDATA;
			end
			con_d[c] = wr_con[c] ? (I_WDATA & con_mask(c)) : con_q[c];
			per_d[c] = wr_per[c] ? I_WDATA : per_q[c];
		end
		// Write one to clear; a flag event in the same cycle wins.
		flg_d = (flg_q & ~(wr_flag ? I_WDATA[N_CH-1:0] : 3'h0)) | set_flg;
	end

	// Read multiplexer; unmapped addresses return zero.
	always_comb
	begin
		rdata_d = 16'h0000;
		for (int c = 0; c < N_CH; c++)
		begin
			if (I_ADDR == addr_of(c, A_CON_OFS))
			begin
				rdata_d = con_q[c];
			end
			if (I_ADDR == addr_of(c, A_CNT_OFS))
			begin
				rdata_d = cnt_q[c];
			end
			if (I_ADDR == addr_of(c, A_PER_OFS))
			begin
				rdata_d = per_q[c];
			end
		end
		if (I_ADDR == A_FLAG)
		begin
			rdata_d = {13'h0000, flg_q};
		end
	end

	// Channel state registers.
	always_ff @(posedge I_CORE_CLK)
	begin
		for (int c = 0; c < N_CH; c++)
		begin
			if (I_SRST)
			begin
				con_q[c] <= CON_RST;
				cnt_q[c] <= CNT_RST;
				per_q[c] <= PER_RST;
				psc_q[c] <= 8'h00;
			end
			else
			begin
				con_q[c] <= con_d[c];
				cnt_q[c] <= cnt_d[c];
				per_q[c] <= per_d[c];
				psc_q[c] <= psc_d[c];
			end
		end
	end

	// Flags, trigger pulse and read data.
	always_ff @(posedge I_CORE_CLK)
	begin
		if (I_SRST)
		begin
			flg_q <= 3'h0;
			conv_q <= 1'b0;
			rdata_q <= 16'h0000;
		end
		else
		begin
			flg_q <= flg_d;
			conv_q <= conv_d;
			rdata_q <= I_RD ? rdata_d : 16'h0000;
		end
	end

	assign O_RDATA = rdata_q;
	assign O_S_IRQ = flg_q[CH_S];
	assign O_L_IRQ = flg_q[CH_L];
	assign O_U_IRQ = flg_q[CH_U];
	assign O_CONV_TRIG = conv_q;

	// Standalone channel running 1:8 on the internal clock, undisturbed.
	wire ps8_run = run[CH_S] && !ext[CH_S] && !gmode[CH_S] && !wr_con[CH_S] &&
		(econ[CH_S][B_PS_HI:B_PS_LO] == 2'b01);

	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (I_SRST);

	stop_holds_a: assert property (
		!con_q[CH_S][B_RUN] && !wr_cnt[CH_S] |=> cnt_q[CH_S] == $past(cnt_q[CH_S]))
		else $error("Stopped timer changed its count.");
	idle_halt_a: assert property (
		I_IDLE && con_q[CH_L][B_IDLE] && !wr_cnt[CH_L] |=> $stable(cnt_q[CH_L]))
		else $error("Timer counted during Idle with idle stop set.");
	match_reload_a: assert property (
		tick[CH_S] && match[CH_S] && !wr_cnt[CH_S] |=> cnt_q[CH_S] == 16'h0000 && O_S_IRQ)
		else $error("Period match did not reload and flag.");
	prescale_eight_a: assert property (
		(psc_q[CH_S] == 8'h00 && ps8_run) ##1 ps8_run [*7] |-> tick[CH_S])
		else $error("Prescaler 1:8 did not tick on the eighth clock.");
	gate_hold_a: assert property (
		gmode[CH_S] && !p_lvl[CH_S] && !wr_cnt[CH_S] |=> $stable(cnt_q[CH_S]))
		else $error("Gated timer counted with gate low.");
	ext_edge_only_a: assert property (
		ext[CH_S] && !p_rise[CH_S] && !wr_cnt[CH_S] |=> $stable(cnt_q[CH_S]))
		else $error("External clock timer counted without an edge.");
	cascade_count_a: assert property (
		casc && tick[CH_L] && !m32 && !wr_cnt[CH_L] && !wr_cnt[CH_U]
		|=> {cnt_q[CH_U], cnt_q[CH_L]} == $past(cnt32) + 32'h0000_0001)
		else $error("Cascaded count did not advance as one 32-bit value.");
	cascade_flag_a: assert property (
		casc && tick[CH_L] && m32 |=> O_U_IRQ && O_CONV_TRIG && $stable(flg_q[CH_L]))
		else $error("Cascaded match not signalled through the upper flag.");
	upper_trig_a: assert property (
		!casc && tick[CH_U] && match[CH_U] |=> O_CONV_TRIG)
		else $error("Upper period match gave no converter trigger.");
	ctrl_psc_clear_a: assert property (
		wr_con[CH_L] && con_q[CH_L][B_RUN] |=> psc_q[CH_L] == 8'h00)
		else $error("Control write while running kept the prescaler.");
	unimpl_zero_a: assert property (
		I_RD && I_ADDR == addr_of(CH_S, A_CON_OFS) |=> (O_RDATA & ~MASK_S) == 16'h0000)
		else $error("Unimplemented control bits read non-zero.");
	flag_set_wins_a: assert property (
		set_flg[CH_S] && wr_flag && I_WDATA[CH_S] |=> O_S_IRQ)
		else $error("Flag event lost against a clear.");

	// A tick below the period advances the count by exactly one.
	step_one_a: assert property (
		tick[CH_S] && !match[CH_S] && !wr_cnt[CH_S] |=> cnt_q[CH_S] == $past(cnt_q[CH_S]) + 16'h0001)
		else $error("Standalone count did not step by one.");

	// A lower match in 16-bit mode reloads zero and raises the lower flag.
	lower_reload_a: assert property (
		!casc && tick[CH_L] && match[CH_L] && !wr_cnt[CH_L] |=> cnt_q[CH_L] == 16'h0000 && O_L_IRQ)
		else $error("Lower period match did not reload and flag.");

	// An upper match in 16-bit mode reloads zero and raises the upper flag.
	upper_reload_a: assert property (
		!casc && tick[CH_U] && match[CH_U] && !wr_cnt[CH_U] |=> cnt_q[CH_U] == 16'h0000 && O_U_IRQ)
		else $error("Upper period match did not reload and flag.");

	// A synchronised gate fall while gated and running always leaves the flag set.
	gate_fall_flag_a: assert property (
		gfall[CH_S] |=> O_S_IRQ)
		else $error("Gate falling edge did not set the flag.");

	// A timer that is not running keeps its prescaler at zero, so a restart is clean.
	stop_psc_zero_a: assert property (
		!run[CH_L] |=> psc_q[CH_L] == 8'h00)
		else $error("Stopped timer kept a prescale count.");

	// Cascaded, the upper prescaler is parked; its own settings must not leak in.
	cascade_psc_idle_a: assert property (
		casc |=> psc_q[CH_U] == 8'h00)
		else $error("Upper prescaler ran while cascaded.");

	// Cascaded, the lower flag can only fall, never rise.
	lower_flag_quiet_a: assert property (
		casc && !flg_q[CH_L] |=> !O_L_IRQ)
		else $error("Lower flag rose while cascaded.");

	// Cascaded with the lower run bit clear, the 32-bit count stands still.
	cascade_stop_a: assert property (
		casc && !con_q[CH_L][B_RUN] && !wr_cnt[CH_U] && !wr_cnt[CH_L]
		|=> {cnt_q[CH_U], cnt_q[CH_L]} == $past(cnt32))
		else $error("Stopped cascaded counter moved.");

	// A 32-bit match against the combined period reloads both words to zero.
	cascade_reload_a: assert property (
		casc && tick[CH_L] && m32 && !wr_cnt[CH_L] && !wr_cnt[CH_U] |=> cnt32 == 32'h0000_0000)
		else $error("Cascaded match did not reload the 32-bit count.");

	// The upper control register never holds a bit outside its implemented set.
	con_mask_a: assert property (
		(con_q[CH_U] & ~MASK_U) == 16'h0000)
		else $error("Unimplemented upper control bit was stored.");

	// Writing one to a flag bit clears it when no event competes.
	flag_clear_a: assert property (
		wr_flag && I_WDATA[CH_L] && !set_flg[CH_L] |=> !O_L_IRQ)
		else $error("Flag write did not clear the lower flag.");

	// With idle_stop clear, Idle must not stop a running timer.
	idle_run_on_a: assert property (
		I_IDLE && !econ[CH_S][B_IDLE] && econ[CH_S][B_RUN] |-> run[CH_S])
		else $error("Timer stopped in Idle with idle stop clear.");

	// On the lower pin clock, no synchronised rising edge means no count.
	lower_edge_only_a: assert property (
		ext[CH_L] && !p_rise[CH_L] && !wr_cnt[CH_L] |=> $stable(cnt_q[CH_L]))
		else $error("Lower pin clock timer counted without an edge.");

	// Every prescaled tick restarts the prescale sequence from zero.
	psc_wrap_a: assert property (
		tick[CH_L] |=> psc_q[CH_L] == 8'h00)
		else $error("Prescaler did not restart after a tick.");
endmodule : cpt_timers

/* cpt_pin_model.sv */
// Outside clock and gate source that drives one timer pin.
`timescale 1ns/10ps
module cpt_pin_model (
	input wire logic i_clk,
	input wire logic i_run,
	input wire logic i_lvl,
	output logic o_pin,
	output int o_edges
);
	int ph;
	// Start low with no edges made.
	initial
	begin
		o_pin = 1'b0;
		o_edges = 0;
		ph = 0;
	end
	// A running source toggles every third cycle and counts its rising edges.
	// A stopped one sits still at the chosen level, so it can also serve as a gate.
	always @(posedge i_clk)
	begin
		ph <= (ph == 2) ? 0 : ph + 1;
		if (!i_run)
			o_pin <= i_lvl;
		else if (ph == 2)
		begin
			o_pin <= !o_pin;
			o_edges <= o_edges + int'(!o_pin);
		end
	end
endmodule : cpt_pin_model

/* cascadable_period_timers_bench.sv */
// Self-checking bench for the timer block, with random and corner stimulus.
`timescale 1ns/10ps
module cascadable_period_timers_bench
	import cpt_pkg::*;
;
	logic clk, srst, wr, rd, idle, s_irq, l_irq, u_irq, trig;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, v, w, cv;
	logic [2:0] run, lvl, pin, irq;
	logic [1:0] ps;
	logic [15:0] seed = 16'hD58D;
	int eds[3];
	int n_errors = 0, check_count = 0, cyc = 0, trigs = 0, n, c, p, t0;
	assign irq = {u_irq, l_irq, s_irq};
	cpt_timers cpt_timers_i (.I_CORE_CLK(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_IDLE(idle), .I_S_ECLK(pin[0]),
		.I_L_ECLK(pin[1]), .I_U_ECLK(pin[2]), .O_S_IRQ(s_irq), .O_L_IRQ(l_irq),
		.O_U_IRQ(u_irq), .O_CONV_TRIG(trig));
	for (genvar g = 0; g < 3; g++)
	begin : pins
		cpt_pin_model cpt_pin_model_i (.i_clk(clk), .i_run(run[g]), .i_lvl(lvl[g]),
			.o_pin(pin[g]), .o_edges(eds[g]));
	end
	// Free-running clock.
	initial
	begin
		clk = 1'b0;
		forever #10 clk = !clk;
	end
	// Xorshift step for repeatable random values.
	function automatic logic [15:0] nxt(input logic [15:0] s);
		logic [15:0] t;
		t = s ^ (s << 7);
		t = t ^ (t >> 9);
		nxt = t ^ (t << 8);
	endfunction : nxt
	// Readback of a control word: only the implemented bits survive.
	function automatic logic [15:0] con_exp(input int k, input logic [15:0] d);
		con_exp = d & ((k == 0) ? 16'hA076 : ((k == 1) ? 16'hA07A : 16'hA072));
	endfunction : con_exp
	// Cycles from start to the first match for a period and prescale code.
	function automatic int span(input int pr, input logic [1:0] s);
		span = (pr + 1) * ((s == 2'd0) ? 1 : ((s == 2'd1) ? 8 : ((s == 2'd2) ? 64 : 256)));
	endfunction : span
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wreg
	// Read data stand only in the cycle after the strobe, so sample them mid-cycle.
	task automatic rreg(input logic [3:0] a, output logic [15:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask : rreg
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
		rreg(a, v);
		chk(v, exp);
	endtask : rchk
	// Bounded wait for a flag, sampled away from the clock edge.
	task automatic wait_irq(input int k, output int cnt);
		cnt = 0;
		while (irq[k] !== 1'b1 && cnt < 2000)
		begin
			@(negedge clk);
			cnt++;
		end
		@(posedge clk);
	endtask : wait_irq
	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	// Trigger pulse counter and hang guard.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		trigs <= trigs + int'(trig === 1'b1);
		if (cyc == 20000)
		begin
			n_errors++;
			wrap_up();
		end
	end
	initial
	begin
		srst = 1'b1;
		{wr, rd, idle, addr, wdata, run, lvl} = '0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		for (int k = 0; k < 9; k++)
			rchk(4'(k), (k % 3 == 2) ? 16'hFFFF : 16'h0000);
		$display("reset values done");
		// Random control words; the first three set every bit but run.
		for (int i = 0; i < 12; i++)
		begin
			seed = nxt(seed);
			w = (i < 3) ? 16'h7FFF : (seed & 16'h7FFF);
			wreg(4'((i % 3) * 3), w);
			rchk(4'((i % 3) * 3), con_exp(i % 3, w));
			wreg(4'((i % 3) * 3), 16'h0000);
		end
		wreg(4'hF, 16'hFFFF);
		for (int a = 10; a < 16; a++)
			rchk(4'(a), 16'h0000);
		$display("control masks done");
		// Every prescale code on every timer, short random periods.
		for (int i = 0; i < 12; i++)
		begin
			c = i % 3;
			ps = 2'(i / 3);
			seed = nxt(seed);
			p = int'(seed[1:0]) + 3;
			wreg(4'(c * 3 + 2), 16'(p));
			wreg(4'(c * 3 + 1), 16'h0000);
			wreg(A_FLAG, 16'h0007);
			t0 = trigs;
			wreg(4'(c * 3), {8'h80, 2'b00, ps, 4'h0});
			wait_irq(c, n);
			wreg(4'(c * 3), 16'h0000);
			chk(16'(n >= span(p, ps) - 1 && n <= span(p, ps) + 3), 16'h0001);
			chk({13'h0, irq}, 16'h0001 << c);
			chk(16'(trigs - t0), 16'((c == 2) ? 1 : 0));
			rreg(4'(c * 3 + 1), w);
			rchk(4'(c * 3 + 1), w);
			wreg(4'(c * 3 + 2), 16'hFFFF);
		end
		$display("prescale and match done");
		// Idle halts only a timer whose idle_stop bit is set.
		idle <= 1'b1;
		wreg(4'h1, 16'h0000);
		wreg(4'h0, 16'hA000);
		repeat (20) @(posedge clk);
		rchk(4'h1, 16'h0000);
		wreg(4'h0, 16'h8000);
		repeat (20) @(posedge clk);
		wreg(4'h0, 16'h0000);
		rreg(4'h1, v);
		chk(16'(v >= 19 && v <= 25), 16'h0001);
		idle <= 1'b0;
		$display("idle done");
		// Gated accumulation: hold while low, count while high, flag on the fall.
		wreg(4'h1, 16'h0000);
		wreg(A_FLAG, 16'h0007);
		wreg(4'h0, 16'h8040);
		repeat (20) @(posedge clk);
		rchk(4'h1, 16'h0000);
		lvl[0] <= 1'b1;
		repeat (30) @(posedge clk);
		lvl[0] <= 1'b0;
		repeat (8) @(posedge clk);
		wreg(4'h0, 16'h0000);
		rreg(4'h1, v);
		chk(16'(v >= 28 && v <= 32), 16'h0001);
		chk({13'h0, irq}, 16'h0001);
		$display("gate done");
		// Pin clocks: synchronised, lower timer, and asynchronous; gate bit set but ignored.
		for (int k = 0; k < 3; k++)
		begin
			c = (k == 1) ? 1 : 0;
			cv = (k == 0) ? 16'h8046 : 16'h8042;
			wreg(4'(c * 3 + 1), 16'h0000);
			wreg(A_FLAG, 16'h0007);
			wreg(4'(c * 3), cv);
			t0 = eds[c];
			run[c] <= 1'b1;
			repeat (60) @(posedge clk);
			run[c] <= 1'b0;
			repeat (8) @(posedge clk);
			wreg(4'(c * 3), 16'h0000);
			rchk(4'(c * 3 + 1), 16'(eds[c] - t0));
			chk({13'h0, irq}, 16'h0000);
		end
		$display("pin clocks done");
		// Cascade with the upper control holding a stray prescale that must be ignored.
		wreg(4'h5, 16'h0000);
		wreg(4'h8, 16'h0001);
		wreg(4'h4, 16'hFFFD);
		wreg(4'h7, 16'h0000);
		wreg(4'h6, 16'h0030);
		wreg(A_FLAG, 16'h0007);
		t0 = trigs;
		wreg(4'h3, 16'h8008);
		wait_irq(2, n);
		wreg(4'h3, 16'h0000);
		chk(16'(n >= 2 && n <= 6), 16'h0001);
		chk({13'h0, irq}, 16'h0004);
		chk(16'(trigs - t0), 16'h0001);
		wreg(4'h8, 16'hFFFF);
		wreg(4'h5, 16'hFFFF);
		wreg(4'h4, 16'hFFF0);
		wreg(4'h7, 16'h0000);
		wreg(4'h3, 16'h8008);
		repeat (30) @(posedge clk);
		wreg(4'h3, 16'h0000);
		rchk(4'h7, 16'h0001);
		$display("cascade done");
		wrap_up();
	end
endmodule : cascadable_period_timers_bench
